// ===== rtl/video_sync_timing.sv
// video sync timing: master/slave sync pins, line/field adjust, field flag, wishbone registers
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
module video_sync_timing
  import video_sync_pkg::*;
(
  // double-rate clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // pixel clock pin
  input  wire logic        pclk_i,
  output logic             pclk_o,
  output logic             pclk_oe_b_o,
  // horizontal sync pin
  input  wire logic        hsync_i,
  output logic             hsync_o,
  output logic             hsync_oe_b_o,
  // vertical sync pin
  input  wire logic        vsync_i,
  output logic             vsync_o,
  output logic             vsync_oe_b_o,
  // composite blank pin
  input  wire logic        blank_i,
  output logic             blank_o,
  output logic             blank_oe_b_o,
  // field indicator and encoder controls
  output logic             field_o,
  output video_level_t     video_level_o,
  output logic             pix_tick_o,
  // two-wire address select
  input  wire logic        bus_address_select_i,
  output logic [6:0]       tw_slave_addr_o
);

  // ****************************************
  // configuration and state registers
  // ****************************************
  logic [CTRL_W-1:0] ctrl_ff;
  logic [H_W-1:0]    htotal_ff;
  logic [H_W-1:0]    hsync_w_ff;
  logic [H_W-1:0]    hact_beg_ff;
  logic [H_W-1:0]    hact_end_ff;
  logic [V_W-1:0]    vtotal_ff;
  logic [V_W-1:0]    vsync_w_ff;
  logic [V_W-1:0]    vact_beg_ff;
  logic [V_W-1:0]    vact_end_ff;
  logic [FDW_W-1:0]  fdw_ff;
  logic [H_W-1:0]    h_ff;
  logic [V_W-1:0]    v_ff;
  logic              hwait_ff;
  logic              vwait_ff;
  logic              field_ff;
  logic [FDW_W-1:0]  win_ff;
  logic              field_out_ff;
  video_level_t      level_ff;
  logic              ack_ff;
  logic [31:0]       rdat_ff;
  logic [6:0]        tw_addr_ff;

  // ****************************************
  // decoded controls
  // ****************************************
  wire master   = ctrl_ff[CTRL_MASTER_BIT];
  wire div4     = ctrl_ff[CTRL_DIV4_BIT];
  wire pclk_out = ctrl_ff[CTRL_PCLK_OUT_BIT];
  wire fd_sel   = ctrl_ff[CTRL_FD_SEL_BIT];
  wire pix_tick;

  // true when lo <= x < hi
  function automatic logic in_span(input logic [H_W-1:0] x,
                                   input logic [H_W-1:0] lo,
                                   input logic [H_W-1:0] hi);
    in_span = (x >= lo) && (x < hi);
  endfunction

  // ****************************************
  // pixel clock
  // ****************************************
  pixel_clock_gen u_pclk (.core_clk_i, .rst_b_i, .pclk_out_i(pclk_out), .div4_i(div4), .pclk_i,
    .pclk_o, .pclk_oe_b_o, .pix_tick_o(pix_tick));

  // ****************************************
  // internally generated sync levels
  // ****************************************
  wire gen_hs  = h_ff < hsync_w_ff;
  wire gen_vs  = v_ff < vsync_w_ff;
  wire h_act   = in_span(h_ff, hact_beg_ff, hact_end_ff);
  wire v_act   = in_span({1'b0, v_ff}, {1'b0, vact_beg_ff}, {1'b0, vact_end_ff});
  wire gen_blk = ~(h_act & v_act);

  wire hs_act, vs_act, blk_act, hs_lead, vs_lead;

  // one pin block per sync signal, each with its own polarity bit
  sync_pin_io u_hs (.core_clk_i, .rst_b_i, .master_i(master), .active_high_i(ctrl_ff[CTRL_POL_HS_BIT]),
    .drive_act_i(gen_hs), .pin_i(hsync_i), .pin_o(hsync_o), .pin_oe_b_o(hsync_oe_b_o),
    .in_act_o(hs_act), .in_lead_o(hs_lead));
  sync_pin_io u_vs (.core_clk_i, .rst_b_i, .master_i(master), .active_high_i(ctrl_ff[CTRL_POL_VS_BIT]),
    .drive_act_i(gen_vs), .pin_i(vsync_i), .pin_o(vsync_o), .pin_oe_b_o(vsync_oe_b_o),
    .in_act_o(vs_act), .in_lead_o(vs_lead));
  sync_pin_io u_blk (.core_clk_i, .rst_b_i, .master_i(master), .active_high_i(ctrl_ff[CTRL_POL_BLK_BIT]),
    .drive_act_i(gen_blk), .pin_i(blank_i), .pin_o(blank_o), .pin_oe_b_o(blank_oe_b_o),
    .in_act_o(blk_act), .in_lead_o());

  // ****************************************
  // horizontal counter
  // ****************************************
  wire h_last = h_ff == (htotal_ff - 11'h001);
  logic [H_W-1:0] nxt_h;
  logic           nxt_hwait;
  logic           line_end;

  // a slave restarts on the sync edge whether early or late
  always_comb begin
    nxt_h     = h_ff;
    nxt_hwait = hwait_ff;
    line_end  = 1'b0;
    if (master) begin
      nxt_hwait = 1'b0;
      if (pix_tick) begin
        nxt_h    = h_last ? '0 : h_ff + 11'h001;
        line_end = h_last;
      end
    end else if (hs_lead) begin
      nxt_h     = '0;
      nxt_hwait = 1'b0;
      line_end  = 1'b1;
    end else if (pix_tick) begin
      if (h_last || hwait_ff) begin
        nxt_hwait = 1'b1;
      end else begin
        nxt_h = h_ff + 11'h001;
      end
    end
  end

  // ****************************************
  // vertical counter
  // ****************************************
  wire v_last = v_ff == (vtotal_ff - 10'h001);
  logic [V_W-1:0] nxt_v;
  logic           nxt_vwait;
  logic           field_end;

  // vertical edge beats a simultaneous line end
  always_comb begin
    nxt_v     = v_ff;
    nxt_vwait = vwait_ff;
    field_end = 1'b0;
    if (master) begin
      nxt_vwait = 1'b0;
      if (line_end) begin
        nxt_v     = v_last ? '0 : v_ff + 10'h001;
        field_end = v_last;
      end
    end else if (vs_lead) begin
      nxt_v     = '0;
      nxt_vwait = 1'b0;
      field_end = 1'b1;
    end else if (line_end) begin
      if (v_last || vwait_ff) begin
        nxt_vwait = 1'b1;
      end else begin
        nxt_v = v_ff + 10'h001;
      end
    end
  end

  // ****************************************
  // field tracking and detect window
  // ****************************************
  wire win_open = win_ff < fdw_ff;
  logic [FDW_W-1:0] nxt_win;
  logic             nxt_field;

  // window counts pixels from the vertical edge; detection overrides toggling
  always_comb begin
    nxt_win   = win_ff;
    nxt_field = field_ff;
    if (vs_lead) begin
      nxt_win = '0;
    end else if (pix_tick && win_open) begin
      nxt_win = win_ff + 9'h001;
    end
    if (field_end) begin
      nxt_field = ~field_ff;
    end
    if (!master && hs_lead && (vs_lead || win_open)) begin
      nxt_field = fd_sel;
    end
  end

  // ****************************************
  // output level toward the encoder path
  // ****************************************
  wire sync_now = master ? (gen_hs | gen_vs) : (hs_act | vs_act);
  wire blk_now  = master ? gen_blk : blk_act;
  video_level_t nxt_level;

  // a stretched line holds porch level; a stretched field holds blanking
  always_comb begin
    if (!master && hwait_ff) begin
      nxt_level = LVL_PORCH;
    end else if (!master && vwait_ff) begin
      nxt_level = LVL_BLANK;
    end else if (sync_now) begin
      nxt_level = LVL_SYNC;
    end else if (blk_now) begin
      nxt_level = LVL_BLANK;
    end else begin
      nxt_level = LVL_ACTIVE;
    end
  end

  // timing state
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      h_ff         <= '0;
      v_ff         <= '0;
      hwait_ff     <= 1'b0;
      vwait_ff     <= 1'b0;
      field_ff     <= 1'b0;
      win_ff       <= '0;
      field_out_ff <= 1'b0;
      level_ff     <= LVL_BLANK;
    end else begin
      h_ff         <= nxt_h;
      v_ff         <= nxt_v;
      hwait_ff     <= nxt_hwait;
      vwait_ff     <= nxt_vwait;
      field_ff     <= nxt_field;
      win_ff       <= nxt_win;
      field_out_ff <= field_ff ~^ ctrl_ff[CTRL_POL_FLD_BIT];
      level_ff     <= nxt_level;
    end
  end

  assign field_o       = field_out_ff;
  assign video_level_o = level_ff;
  assign pix_tick_o    = pix_tick;

  // ****************************************
  // two-wire address select
  // ****************************************
  // the select level is sampled every cycle so a strap needs no special capture
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      tw_addr_ff <= TW_ADDR_SA_LO;
    end else begin
      tw_addr_ff <= bus_address_select_i ? TW_ADDR_SA_HI : TW_ADDR_SA_LO;
    end
  end
  assign tw_slave_addr_o = tw_addr_ff;

  // ****************************************
  // wishbone register slave
  // ****************************************
  wire req    = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr     = req & wb_we_i;
  wire wr_lo  = wr & wb_sel_i[0];
  wire wr_b1  = wr & wb_sel_i[1];
  wire wr_b2  = wr & wb_sel_i[2];
  wire wr_b3  = wr & wb_sel_i[3];
  wire a_ctrl = wb_adr_i == CTRL_OFF;
  wire a_ht0  = wb_adr_i == HTIME0_OFF;
  wire a_ht1  = wb_adr_i == HTIME1_OFF;
  wire a_vt0  = wb_adr_i == VTIME0_OFF;
  wire a_vt1  = wb_adr_i == VTIME1_OFF;
  wire a_fdw  = wb_adr_i == FDW_OFF;
  wire a_st   = wb_adr_i == STATUS_OFF;

  // read mux, unmapped offsets read as zero
  wire [31:0] rd_mux =
    a_ctrl ? {24'h000000, ctrl_ff} :
    a_ht0  ? {5'h00, hsync_w_ff, 5'h00, htotal_ff} :
    a_ht1  ? {5'h00, hact_end_ff, 5'h00, hact_beg_ff} :
    a_vt0  ? {6'h00, vsync_w_ff, 6'h00, vtotal_ff} :
    a_vt1  ? {6'h00, vact_end_ff, 6'h00, vact_beg_ff} :
    a_fdw  ? {23'h000000, fdw_ff} :
    a_st   ? {1'b0, vwait_ff, hwait_ff, field_ff, 2'h0, v_ff, 5'h00, h_ff} :
             32'h00000000;

  // bus handshake: ack one cycle after the request, never two in a row
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ack_ff  <= req;
      rdat_ff <= req ? rd_mux : rdat_ff;
    end
  end

  // control and field detect window registers; byte lanes honoured per field
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ctrl_ff <= CTRL_RST;
      fdw_ff  <= FDW_RST;
    end else begin
      if (wr_lo && a_ctrl) ctrl_ff <= wb_dat_i[CTRL_W-1:0];
      if (a_fdw && wr_lo) fdw_ff[7:0] <= wb_dat_i[7:0];
      if (a_fdw && wr_b1) fdw_ff[8] <= wb_dat_i[8];
    end
  end

  // horizontal and vertical timing registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      htotal_ff   <= HTOTAL_RST;
      hsync_w_ff  <= HSYNC_W_RST;
      hact_beg_ff <= HACT_BEG_RST;
      hact_end_ff <= HACT_END_RST;
      vtotal_ff   <= VTOTAL_RST;
      vsync_w_ff  <= VSYNC_W_RST;
      vact_beg_ff <= VACT_BEG_RST;
      vact_end_ff <= VACT_END_RST;
    end else begin
      if (a_ht0 && wr_lo) htotal_ff[7:0] <= wb_dat_i[7:0];
      if (a_ht0 && wr_b1) htotal_ff[10:8] <= wb_dat_i[10:8];
      if (a_ht0 && wr_b2) hsync_w_ff[7:0] <= wb_dat_i[23:16];
      if (a_ht0 && wr_b3) hsync_w_ff[10:8] <= wb_dat_i[26:24];
      if (a_ht1 && wr_lo) hact_beg_ff[7:0] <= wb_dat_i[7:0];
      if (a_ht1 && wr_b1) hact_beg_ff[10:8] <= wb_dat_i[10:8];
      if (a_ht1 && wr_b2) hact_end_ff[7:0] <= wb_dat_i[23:16];
      if (a_ht1 && wr_b3) hact_end_ff[10:8] <= wb_dat_i[26:24];
      if (a_vt0 && wr_lo) vtotal_ff[7:0] <= wb_dat_i[7:0];
      if (a_vt0 && wr_b1) vtotal_ff[9:8] <= wb_dat_i[9:8];
      if (a_vt0 && wr_b2) vsync_w_ff[7:0] <= wb_dat_i[23:16];
      if (a_vt0 && wr_b3) vsync_w_ff[9:8] <= wb_dat_i[25:24];
      if (a_vt1 && wr_lo) vact_beg_ff[7:0] <= wb_dat_i[7:0];
      if (a_vt1 && wr_b1) vact_beg_ff[9:8] <= wb_dat_i[9:8];
      if (a_vt1 && wr_b2) vact_end_ff[7:0] <= wb_dat_i[23:16];
      if (a_vt1 && wr_b3) vact_end_ff[9:8] <= wb_dat_i[25:24];
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

endmodule

// ===== pkg/video_sync_pkg.sv
// constants shared by the video sync timing block
package video_sync_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [4:0] CTRL_OFF   = 5'h00;
  localparam logic [4:0] HTIME0_OFF = 5'h04;
  localparam logic [4:0] HTIME1_OFF = 5'h08;
  localparam logic [4:0] VTIME0_OFF = 5'h0c;
  localparam logic [4:0] VTIME1_OFF = 5'h10;
  localparam logic [4:0] FDW_OFF    = 5'h14;
  localparam logic [4:0] STATUS_OFF = 5'h18;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTRL_MASTER_BIT   = 0;
  localparam int CTRL_DIV4_BIT     = 1;
  localparam int CTRL_PCLK_OUT_BIT = 2;
  localparam int CTRL_FD_SEL_BIT   = 3;
  localparam int CTRL_POL_FLD_BIT  = 4;
  localparam int CTRL_POL_HS_BIT   = 5;
  localparam int CTRL_POL_VS_BIT   = 6;
  localparam int CTRL_POL_BLK_BIT  = 7;
  localparam int CTRL_W            = 8;

  // ****************************************
  // timing register fields
  // ****************************************
  localparam int H_W       = 11;
  localparam int V_W       = 10;
  localparam int FDW_W     = 9;
  localparam int LO_POS    = 0;
  localparam int HI_POS    = 16;
  localparam int ST_FLD    = 28;
  localparam int ST_HWAIT  = 29;
  localparam int ST_VWAIT  = 30;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [CTRL_W-1:0] CTRL_RST     = 8'h01;
  localparam logic [H_W-1:0]    HTOTAL_RST   = 11'h35a;
  localparam logic [H_W-1:0]    HSYNC_W_RST  = 11'h040;
  localparam logic [H_W-1:0]    HACT_BEG_RST = 11'h07a;
  localparam logic [H_W-1:0]    HACT_END_RST = 11'h34a;
  localparam logic [V_W-1:0]    VTOTAL_RST   = 10'h106;
  localparam logic [V_W-1:0]    VSYNC_W_RST  = 10'h003;
  localparam logic [V_W-1:0]    VACT_BEG_RST = 10'h015;
  localparam logic [V_W-1:0]    VACT_END_RST = 10'h105;
  localparam logic [FDW_W-1:0]  FDW_RST      = 9'h000;

  // ****************************************
  // two-wire slave addresses, values arbitrary
  // ****************************************
  localparam logic [6:0] TW_ADDR_SA_LO = 7'h20;
  localparam logic [6:0] TW_ADDR_SA_HI = 7'h21;

  // video output level requested from the encoder path
  typedef enum logic [1:0] {
    LVL_ACTIVE = 2'b00,
    LVL_BLANK  = 2'b01,
    LVL_PORCH  = 2'b10,
    LVL_SYNC   = 2'b11
  } video_level_t;

endpackage

// ===== rtl/sync_pin_io.sv
// one programmable-polarity sync or blank pin, driver plus input sampler
`timescale 1ns/100ps
module sync_pin_io
  import video_sync_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  // configuration
  input  wire logic master_i,
  input  wire logic active_high_i,
  // internal active-high level to drive
  input  wire logic drive_act_i,
  // pin
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe_b_o,
  // sampled active-high level and its leading edge
  output logic      in_act_o,
  output logic      in_lead_o
);

  logic pin_ff;
  logic in_ff;
  logic prev_ff;
  logic nxt_pin;
  logic nxt_in;

  // polarity applied on both directions
  assign nxt_pin    = drive_act_i ~^ active_high_i;
  assign nxt_in     = pin_i ~^ active_high_i;
  assign pin_oe_b_o = ~master_i;
  assign pin_o      = pin_ff;
  assign in_act_o   = in_ff;
  // edge only meaningful as a timing slave
  assign in_lead_o  = in_ff & ~prev_ff & ~master_i;

  // pin inputs are synchronous, so one sample flop is enough
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      pin_ff  <= 1'b1;
      in_ff   <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      pin_ff  <= nxt_pin;
      in_ff   <= nxt_in;
      prev_ff <= in_ff;
    end
  end

endmodule

// ===== rtl/pixel_clock_gen.sv
// pixel clock divider from the double-rate clock, or pixel clock input sampler
`timescale 1ns/100ps
module pixel_clock_gen
  import video_sync_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  // configuration
  input  wire logic pclk_out_i,
  input  wire logic div4_i,
  // pixel clock pin
  input  wire logic pclk_i,
  output logic      pclk_o,
  output logic      pclk_oe_b_o,
  // one core cycle per pixel
  output logic      pix_tick_o
);

  logic [1:0] div_ff;
  logic [1:0] nxt_div;
  logic       in_ff;
  logic       prev_ff;
  logic       div_tick;

  // divide by two toggles on bit 0, by four on bit 1
  assign nxt_div     = div4_i ? div_ff + 2'h1 : {1'b0, ~div_ff[0]};
  assign div_tick    = div4_i ? (div_ff == 2'h3) : div_ff[0];
  assign pclk_o      = div4_i ? div_ff[1] : div_ff[0];
  assign pclk_oe_b_o = ~pclk_out_i;
  // external clock is synchronous to the double-rate clock, so edges sample cleanly
  assign pix_tick_o  = pclk_out_i ? div_tick : (in_ff & ~prev_ff);

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      div_ff  <= 2'h0;
      in_ff   <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      in_ff   <= pclk_i;
      prev_ff <= in_ff;
    end
  end

endmodule

// ===== bench/video_sync_timing_sva.sv
// port assertions for the video sync timing block
`timescale 1ns/100ps
module video_sync_timing_sva
  import video_sync_pkg::*;
(
  // clock, reset and bus
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // pins
  input wire logic        pclk_o,
  input wire logic        pclk_oe_b_o,
  input wire logic        hsync_o,
  input wire logic        hsync_oe_b_o,
  input wire logic        vsync_o,
  input wire logic        vsync_oe_b_o,
  input wire logic        blank_o,
  input wire logic        blank_oe_b_o,
  input wire logic        field_o,
  input wire logic        bus_address_select_i,
  input wire logic [6:0]  tw_slave_addr_o
);
  logic [7:0]  ctrl_ff;
  logic [10:0] ht_ff;
  logic [10:0] hw_ff;
  logic [9:0]  vw_ff;
  logic [15:0] age_ff;
  logic [15:0] hs_len_ff;
  logic [15:0] vs_len_ff;
  // write decode and active-high views of the pins
  wire wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  wire hs_act  = hsync_o ^ ~ctrl_ff[CTRL_POL_HS_BIT];
  wire vs_act  = vsync_o ^ ~ctrl_ff[CTRL_POL_VS_BIT];
  wire bk_act  = blank_o ^ ~ctrl_ff[CTRL_POL_BLK_BIT];
  wire mst_ok  = ctrl_ff[CTRL_MASTER_BIT] & ctrl_ff[CTRL_PCLK_OUT_BIT] & ~ctrl_ff[CTRL_DIV4_BIT];
  // shadow registers, taken on the same edge as the design
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ctrl_ff <= CTRL_RST;
      ht_ff   <= HTOTAL_RST;
      hw_ff   <= HSYNC_W_RST;
      vw_ff   <= VSYNC_W_RST;
    end else if (wr_take && wb_adr_i == CTRL_OFF) begin
      ctrl_ff <= wb_dat_i[7:0];
    end else if (wr_take && wb_adr_i == HTIME0_OFF) begin
      ht_ff <= wb_dat_i[10:0];
      hw_ff <= wb_dat_i[26:16];
    end else if (wr_take && wb_adr_i == VTIME0_OFF) begin
      vw_ff <= wb_dat_i[25:16];
    end
  end
  // pulse lengths; age keeps pulses cut by a write out of the checks
  always_ff @(posedge core_clk_i) begin
    age_ff    <= (!rst_b_i || wr_take) ? 16'h0000 : age_ff + {15'h0000, age_ff != 16'hffff};
    hs_len_ff <= hs_act ? hs_len_ff + 16'h0001 : 16'h0000;
    vs_len_ff <= vs_act ? vs_len_ff + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not one cycle after request");
  oe_map_a: assert property (
    {hsync_oe_b_o, vsync_oe_b_o, blank_oe_b_o, pclk_oe_b_o} == {{3{~ctrl_ff[0]}}, ~ctrl_ff[2]})
    else $error("pin enables do not follow mode");
  pclk_half_a: assert property (
    ctrl_ff[2] && !ctrl_ff[1] && age_ff > 16'h0008 |-> pclk_o != $past(pclk_o))
    else $error("pixel clock not half rate");
  hs_width_a: assert property (
    mst_ok && $fell(hs_act) && age_ff > hs_len_ff + 16'h0002 |-> hs_len_ff == {4'h0, hw_ff, 1'b0})
    else $error("hsync pulse width wrong");
  vs_width_a: assert property (
    mst_ok && $fell(vs_act) && age_ff > vs_len_ff + 16'h0002 |-> vs_len_ff == {5'h00, vw_ff, 1'b0} * {5'h00, ht_ff})
    else $error("vsync pulse width wrong");
  sync_blank_a: assert property (
    ctrl_ff[0] && age_ff > 16'h0004 && (hs_act || vs_act) |-> bk_act)
    else $error("sync outside blanking");
  field_move_a: assert property (
    ctrl_ff[0] && age_ff > 16'h0004 && $changed(field_o) |-> ##[0:2] vs_act)
    else $error("field flag moved away from vsync");
  slave_addr_a: assert property (
    $past(rst_b_i) |-> tw_slave_addr_o == ($past(bus_address_select_i) ? TW_ADDR_SA_HI : TW_ADDR_SA_LO))
    else $error("slave address does not follow select");
  cover property (mst_ok && $fell(hs_act));
  cover property (mst_ok && $fell(vs_act));
  cover property (!ctrl_ff[0] && $changed(field_o));
endmodule

bind video_sync_timing video_sync_timing_sva i_video_sync_timing_sva (.*);

// ===== bench/video_source_model.sv
// video source model: free-running pixel clock and slave sync drive
`timescale 1ns/100ps
module video_source_model (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // line length in pixels, field length in lines
  input  wire logic [10:0] line_px_i,
  input  wire logic [9:0]  field_ln_i,
  // design drive and enables of the pins
  input  wire logic        hs_drv_i,
  input  wire logic        hs_oe_b_i,
  input  wire logic        vs_drv_i,
  input  wire logic        vs_oe_b_i,
  input  wire logic        bk_drv_i,
  input  wire logic        bk_oe_b_i,
  // resolved pin levels
  output logic             pclk_o,
  output logic             hsync_o,
  output logic             vsync_o,
  output logic             blank_o
);
  logic [10:0] px_ff;
  logic [9:0]  ln_ff;
  logic        pclk_ff = 1'b0;
  // never gated, not even in reset
  always @(posedge core_clk_i) pclk_ff <= ~pclk_ff;
  // raster advances on rising pixel clock; >= copes with a shortened length
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      px_ff <= 11'h000;
      ln_ff <= 10'h000;
    end else if (!pclk_ff && px_ff >= line_px_i - 11'h001) begin
      px_ff <= 11'h000;
      ln_ff <= (ln_ff >= field_ln_i - 10'h001) ? 10'h000 : ln_ff + 10'h001;
    end else if (!pclk_ff) begin
      px_ff <= px_ff + 11'h001;
    end
  end
  // sync and blank active low; design drive wins when enabled
  assign pclk_o  = pclk_ff;
  assign hsync_o = hs_oe_b_i ? (px_ff > 11'h001) : hs_drv_i;
  assign vsync_o = vs_oe_b_i ? (ln_ff != 10'h000) : vs_drv_i;
  assign blank_o = bk_oe_b_i ? (px_ff > 11'h003 && ln_ff > 10'h001) : bk_drv_i;
endmodule

// ===== bench/video_sync_timing_tb.sv
// self-checking bench for the video sync timing block
`timescale 1ns/100ps
module video_sync_timing_tb;
  import video_sync_pkg::*;
  logic         core_clk_i = 1'b0;
  logic         rst_b_i = 1'b0;
  logic         wb_cyc_i = 1'b0;
  logic         wb_stb_i = 1'b0;
  logic         wb_we_i = 1'b0;
  logic [4:0]   wb_adr_i = 5'h00;
  logic [31:0]  wb_dat_i = 32'h0;
  logic [31:0]  wb_dat_o, q;
  logic         wb_ack_o, pclk_i, pclk_o, pclk_oe_b_o, hsync_i, hsync_o, hsync_oe_b_o, pix_tick_o;
  logic         vsync_i, vsync_o, vsync_oe_b_o, blank_i, blank_o, blank_oe_b_o, field_o;
  logic         bus_address_select_i = 1'b0;
  logic [6:0]   tw_slave_addr_o;
  video_level_t video_level_o;
  logic [10:0]  line_px = 11'h014;
  logic [9:0]   field_ln = 10'h008;
  int           n_errors = 0, compares = 0, hs_fall, fld_chg, pc_rise, hs_hi, fld_hi;
  int           p_run, p_max, b_run, b_max, hmax, vmax;

  video_sync_timing i_video_sync_timing (.*, .wb_sel_i(4'hf));
  video_source_model i_video_source_model (.core_clk_i, .rst_b_i, .line_px_i(line_px), .field_ln_i(field_ln),
    .hs_drv_i(hsync_o), .hs_oe_b_i(hsync_oe_b_o), .vs_drv_i(vsync_o), .vs_oe_b_i(vsync_oe_b_o),
    .bk_drv_i(blank_o), .bk_oe_b_i(blank_oe_b_o), .pclk_o(pclk_i), .hsync_o(hsync_i), .vsync_o(vsync_i),
    .blank_o(blank_i));

  // 100 MHz double-rate clock
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic summarize();
    if (n_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // classic single cycle; read data taken on the ack edge
  task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    wb_adr_i <= a;
    wb_we_i  <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      summarize();
    end
  endtask

  // pin statistics over a window; longest runs of porch and blank level
  task automatic watch(input int n);
    logic hq, fq, pq;
    hq = hsync_o;
    fq = field_o;
    pq = pclk_o;
    {hs_fall, fld_chg, pc_rise, hs_hi, fld_hi, p_run, p_max, b_run, b_max} = '0;
    repeat (n) begin
      @(posedge core_clk_i);
      hs_fall += int'(hq && !hsync_o);
      fld_chg += int'(fq !== field_o);
      pc_rise += int'(!pq && pclk_o);
      hs_hi += int'(hsync_o);
      fld_hi += int'(field_o);
      p_run = (video_level_o === LVL_PORCH) ? p_run + 1 : 0;
      b_run = (video_level_o === LVL_BLANK) ? b_run + 1 : 0;
      p_max = (p_run > p_max) ? p_run : p_max;
      b_max = (b_run > b_max) ? b_run : b_max;
      hq = hsync_o;
      fq = field_o;
      pq = pclk_o;
    end
  endtask

  // largest line and field counts over twenty status reads
  task automatic smax(input int gap);
    hmax = 0;
    vmax = 0;
    repeat (20) begin
      wb(STATUS_OFF, 1'b0, 32'h0);
      hmax = (int'(q[10:0]) > hmax) ? int'(q[10:0]) : hmax;
      vmax = (int'(q[25:16]) > vmax) ? int'(q[25:16]) : vmax;
      tick(gap);
    end
  endtask

  // reset values, unmapped read; small raster programmed before the first line ends
  task automatic t_regs();
    wb(CTRL_OFF, 1'b0, 32'h0);
    chk("ctrl reset", q, {24'h0, CTRL_RST});
    wb(HTIME0_OFF, 1'b0, 32'h0);
    chk("htime0 reset", q, {5'h0, HSYNC_W_RST, 5'h0, HTOTAL_RST});
    wb(5'h1c, 1'b0, 32'h0);
    chk("unmapped read", q, 32'h0);
    wb(HTIME0_OFF, 1'b1, 32'h0004_0014);
    wb(HTIME1_OFF, 1'b1, 32'h0012_0006);
    wb(VTIME0_OFF, 1'b1, 32'h0002_0008);
    wb(VTIME1_OFF, 1'b1, 32'h0007_0003);
  endtask

  // master: 20-pixel lines, 8-line fields, 4-pixel hsync
  task automatic t_master();
    wb(CTRL_OFF, 1'b1, 32'h05);
    tick(1000);
    watch(640);
    chk("hsync falls", hs_fall, 16);
    chk("hsync idle high", hs_hi, 512);
    chk("field flips", fld_chg, 2);
    chk("pclk div2", pc_rise, 320);
    wb(CTRL_OFF, 1'b1, 32'h25);
    tick(100);
    watch(640);
    chk("hsync active high", hs_hi, 128);
    wb(CTRL_OFF, 1'b1, 32'h07);
    tick(200);
    watch(640);
    chk("pclk div4", pc_rise, 160);
  endtask

  // slave: early and late line and field edges from the source
  task automatic t_slave();
    wb(CTRL_OFF, 1'b1, 32'h00);
    chk("drivers off", {hsync_oe_b_o, vsync_oe_b_o, blank_oe_b_o, pclk_oe_b_o}, 4'hf);
    line_px <= 11'd12;
    tick(400);
    smax(7);
    chk("short line", hmax < 14, 1);
    line_px <= 11'd30;
    tick(400);
    watch(640);
    chk("line stretch", p_max >= 20, 1);
    line_px <= 11'd20;
    field_ln <= 10'd5;
    tick(800);
    smax(13);
    chk("short field", vmax < 6, 1);
    field_ln <= 10'd12;
    tick(1000);
    watch(1000);
    chk("field stretch", b_max >= 140, 1);
  endtask

  // field select and field polarity, address select, short mid-run reset
  task automatic t_misc();
    field_ln <= 10'd8;
    wb(CTRL_OFF, 1'b1, 32'h18);
    tick(700);
    watch(640);
    chk("field even", fld_hi, 640);
    wb(CTRL_OFF, 1'b1, 32'h10);
    tick(700);
    watch(640);
    chk("field odd", fld_hi, 0);
    bus_address_select_i <= 1'b1;
    tick(3);
    chk("addr high", tw_slave_addr_o, TW_ADDR_SA_HI);
    bus_address_select_i <= 1'b0;
    tick(3);
    chk("addr low", tw_slave_addr_o, TW_ADDR_SA_LO);
    wb(CTRL_OFF, 1'b1, 32'h9e);
    rst_b_i <= 1'b0;
    tick(8);
    rst_b_i <= 1'b1;
    wb(CTRL_OFF, 1'b0, 32'h0);
    chk("ctrl after reset", q, {24'h0, CTRL_RST});
  endtask

  // reset held well beyond four pixel clocks
  initial begin
    tick(20);
    rst_b_i <= 1'b1;
    t_regs();
    t_master();
    t_slave();
    t_misc();
    summarize();
  end
endmodule
